// *** verilog/ssr_pkg.sv ***
package ssr_pkg;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int        SSR_WIDTH     = 8;
	localparam logic [7:0] SSR_RST_SHIFT = 8'h00;
	localparam logic [7:0] SSR_RST_STORE = 8'h00;

	// ------------------------------------------------------------
	// host-side pin group, as sampled from outside
	// ------------------------------------------------------------
	typedef struct packed {
		logic serial_in;
		logic shift_clock;
		logic storage_clock;
		logic shift_clear_n;
		logic storage_clear_n;
	} ssr_pins_t;

endpackage : ssr_pkg

// *** verilog/ssr_sync.sv ***
`timescale 1ns/1ns
// two-flop synchroniser for a bus of pin levels
module ssr_sync #(
	parameter int W = 5
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : ssr_sync

// *** verilog/ssr_top.sv ***
`timescale 1ns/1ns
// Functional notes
// RULE1: eight shift stages load in parallel into an eight-bit storage register
// RULE2: shift clock drives shift register, storage clock drives storage register
// RULE3: each clear empties only its own register and overrides its clock
// RULE4: registers change only on rising edges of their own clocks
// RULE5: last shift stage drives serial cascade output
// RULE6: with tied clocks storage holds shift contents from one edge earlier
// RULE7: host raises shift clock before storage clock when clocks are separate
// RULE8: rising shift edge takes serial input into stage one; clears are level
module ssr_top
	import ssr_pkg::*;
#(
	parameter int WIDTH = ssr_pkg::SSR_WIDTH
) (
	// system
	input  wire logic               clock,
	input  wire logic               nrst,
	// pins from host
	input  wire ssr_pkg::ssr_pins_t pins,
	// outputs
	output logic [WIDTH-1:0]        parallel_out,
	output logic                    serial_cascade_out
);
	import ssr_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	ssr_pins_t  pins_s;
	logic [$bits(ssr_pins_t)-1:0] pins_s_raw;
	logic       shift_clock_prev_q;
	logic       storage_clock_prev_q;
	logic       shift_rise;
	logic       storage_rise;
	logic [WIDTH-1:0] shift_q;

	ssr_sync #(
		.W ($bits(ssr_pins_t))
	) u_sync (
		.clock    (clock),
		.nrst     (nrst),
		.async_in (pins),
		.sync_out (pins_s_raw)
	);
	assign pins_s = ssr_pins_t'(pins_s_raw);

	// RULE2: independent edge detectors
	// shift clock history; resets to the idle low level so no false edge follows reset
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			shift_clock_prev_q <= 1'b0;
		else
			shift_clock_prev_q <= pins_s.shift_clock;
	end

	// storage clock history, kept apart so the two clocks share no state
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			storage_clock_prev_q <= 1'b0;
		else
			storage_clock_prev_q <= pins_s.storage_clock;
	end

	// RULE4: rising edges only
	assign shift_rise   = pins_s.shift_clock & ~shift_clock_prev_q;
	assign storage_rise = pins_s.storage_clock & ~storage_clock_prev_q;

	// ------------------------------------------------------------
	// shift register
	// ------------------------------------------------------------
	// RULE3: clear wins over shift edge
	// RULE8: serial in enters stage zero
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			shift_q <= SSR_RST_SHIFT[WIDTH-1:0];
		else if (!pins_s.shift_clear_n)
			shift_q <= SSR_RST_SHIFT[WIDTH-1:0];
		else if (shift_rise)
			shift_q <= {shift_q[WIDTH-2:0], pins_s.serial_in};
	end

	// ------------------------------------------------------------
	// storage register
	// ------------------------------------------------------------
	// RULE1: parallel load of shift stages
	// RULE6: old shift value captured when both edges coincide
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			parallel_out <= SSR_RST_STORE[WIDTH-1:0];
		else if (!pins_s.storage_clear_n)
			parallel_out <= SSR_RST_STORE[WIDTH-1:0];
		else if (storage_rise)
			parallel_out <= shift_q;
	end

	// RULE5: cascade output follows last stage, registered
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			serial_cascade_out <= 1'b0;
		else if (!pins_s.shift_clear_n)
			serial_cascade_out <= 1'b0;
		else if (shift_rise)
			serial_cascade_out <= shift_q[WIDTH-2];
	end

	// ------------------------------------------------------------
	// helper count of shift edges since the last shift clear
	// ------------------------------------------------------------
	// saturates at the width: the checks only need "not yet full"
	localparam int CNT_W = $clog2(WIDTH + 1);

	logic [CNT_W-1:0] shift_count_q;

	// RULE8: stages fill from serial input
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			shift_count_q <= '0;
		else if (!pins_s.shift_clear_n)
			shift_count_q <= '0;
		else if (shift_rise && shift_count_q < CNT_W'(WIDTH))
			shift_count_q <= shift_count_q + CNT_W'(1);
	end

	// ------------------------------------------------------------
	// shift register checks
	// ------------------------------------------------------------
	// a shift edge moves every stage one place and takes the serial bit
	a_shift_move: assert property (@(posedge clock) disable iff (!nrst) // RULE8
		(shift_rise && pins_s.shift_clear_n) |=> shift_q == {$past(shift_q[WIDTH-2:0]),
		$past(pins_s.serial_in)})
		else $error("shift did not move");

	// a held clear empties the stages whatever the clock does
	a_shift_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		!pins_s.shift_clear_n |=> shift_q == '0 && serial_cascade_out == 1'b0)
		else $error("shift clear failed");

	// no edge, no clear: stages stand
	a_shift_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE2
		(!shift_rise && pins_s.shift_clear_n) |=> $stable(shift_q))
		else $error("shift changed without edge");

	// falling clock edges must leave the stages alone
	a_shift_fall: assert property (@(posedge clock) disable iff (!nrst) // RULE4
		(!pins_s.shift_clock && shift_clock_prev_q && pins_s.shift_clear_n)
		|=> $stable(shift_q))
		else $error("shift moved on falling edge");

	// a storage clear must not disturb the shift stages
	a_shift_own_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		(!pins_s.storage_clear_n && pins_s.shift_clear_n && !shift_rise)
		|=> $stable(shift_q) && $stable(serial_cascade_out))
		else $error("storage clear disturbed shift stages");

	// until a full word has entered, the last stage still shows the clear
	a_fill_empty: assert property (@(posedge clock) disable iff (!nrst) // RULE8
		(shift_count_q < CNT_W'(WIDTH)) |-> serial_cascade_out == 1'b0)
		else $error("cascade set before stages filled");

	// cascade pin and last stage never part
	a_cascade_last: assert property (@(posedge clock) disable iff (!nrst) // RULE5
		1'b1 |-> serial_cascade_out == shift_q[WIDTH-1])
		else $error("cascade not last stage");

	// the cascade bit comes from the stage below the last, one edge back
	a_cascade_feed: assert property (@(posedge clock) disable iff (!nrst) // RULE5
		(shift_rise && pins_s.shift_clear_n)
		|=> serial_cascade_out == $past(shift_q[WIDTH-2]))
		else $error("cascade did not follow shift");

	// ------------------------------------------------------------
	// storage register checks
	// ------------------------------------------------------------
	// a held clear empties the storage register
	a_store_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		!pins_s.storage_clear_n |=> parallel_out == '0)
		else $error("storage clear failed");

	// clear low beats a storage edge in the same cycle
	a_store_clear_wins: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		(!pins_s.storage_clear_n && storage_rise) |=> parallel_out == '0)
		else $error("storage edge beat its clear");

	// a storage edge copies all stages at once
	a_store_load: assert property (@(posedge clock) disable iff (!nrst) // RULE1
		(storage_rise && pins_s.storage_clear_n) |=> parallel_out == $past(shift_q))
		else $error("storage load wrong");

	// no edge, no clear: outputs stand
	a_store_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE4
		(!storage_rise && pins_s.storage_clear_n) |=> $stable(parallel_out))
		else $error("storage changed without edge");

	// a shift clear must not disturb the storage register
	a_store_own_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		(!pins_s.shift_clear_n && pins_s.storage_clear_n && !storage_rise)
		|=> $stable(parallel_out))
		else $error("shift clear disturbed storage");

	// tied clocks: storage takes the old stages while the stages move on
	a_tied_lag: assert property (@(posedge clock) disable iff (!nrst) // RULE6
		(shift_rise && storage_rise && pins_s.shift_clear_n && pins_s.storage_clear_n)
		|=> parallel_out == $past(shift_q)
		&& shift_q == {$past(shift_q[WIDTH-2:0]), $past(pins_s.serial_in)})
		else $error("tied clock lag wrong");

	// ------------------------------------------------------------
	// coverage of the main scenarios
	// ------------------------------------------------------------
	c_shift: cover property (@(posedge clock) disable iff (!nrst) shift_rise);
	c_store: cover property (@(posedge clock) disable iff (!nrst) storage_rise);
	c_tied: cover property (@(posedge clock) disable iff (!nrst) shift_rise && storage_rise);
	c_clear: cover property (@(posedge clock) disable iff (!nrst) !pins_s.shift_clear_n);
	c_full: cover property (@(posedge clock) disable iff (!nrst) shift_count_q == CNT_W'(WIDTH));
endmodule : ssr_top

// *** dv/ssr_host_model.sv ***
`timescale 1ns/1ns
// host side: link clocks, clears and serial data
module ssr_host_model
	import ssr_pkg::*;
(
	// system clock and pins
	input  wire logic          clock,
	output ssr_pkg::ssr_pins_t pins
);
	initial pins = 5'h03;
	// one link period of 8 clocks: 4 low with data set for the last 3, 4 high; low between frames
	task automatic pulse(input logic sh, input logic st, input logic d);
		@(posedge clock) #5 pins.serial_in = d;
		repeat (3) @(posedge clock);
		#5 {pins.shift_clock, pins.storage_clock} = {sh, st};
		repeat (4) @(posedge clock);
		#5 {pins.shift_clock, pins.storage_clock} = 2'h0;
		pins.serial_in = ~d; // hold over, old bit gone
	endtask : pulse
	// clear levels set and left standing, for edges under a held clear
	task automatic set_clear(input logic sh_n, input logic st_n);
		@(posedge clock) #5 {pins.shift_clear_n, pins.storage_clear_n} = {sh_n, st_n};
	endtask : set_clear
	// clears low for 4 clocks
	task automatic clear(input logic sh, input logic st);
		@(posedge clock) #5 {pins.shift_clear_n, pins.storage_clear_n} = {~sh, ~st};
		repeat (4) @(posedge clock);
		#5 {pins.shift_clear_n, pins.storage_clear_n} = 2'h3;
		repeat (4) @(posedge clock);
	endtask : clear
endmodule : ssr_host_model

// *** dv/tb_ssr_top.sv ***
`timescale 1ns/1ns
module tb_ssr_top;
	import ssr_pkg::*;
	logic       clock;
	logic       nrst;
	ssr_pins_t  pins;
	logic [7:0] parallel_out;
	logic       serial_cascade_out;
	logic [7:0] exp_sh;
	logic [7:0] exp_st;
	logic [31:0] lfsr;
	int         n_errors;
	int         total_checks;
	ssr_host_model u_host (.clock(clock), .pins(pins));
	ssr_top dut (.clock(clock), .nrst(nrst), .pins(pins), .parallel_out(parallel_out),
		.serial_cascade_out(serial_cascade_out));
	// 10 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	function automatic logic [7:0] shift_next(input logic [7:0] s, input logic d);
		return {s[6:0], d};
	endfunction : shift_next
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// storage takes the old shift contents before the shift lands
	task automatic step(input logic sh, input logic st, input logic d);
		u_host.pulse(sh, st, d);
		if (st) exp_st = exp_sh;
		if (sh) exp_sh = shift_next(exp_sh, d);
	endtask : step
	// watchdog, run needs about 600 cycles
	initial
	begin
		#200000 n_errors++;
		stop_test();
	end
	initial
	begin
		nrst = 1'b0;
		lfsr = 32'h92d5_0afa;
		exp_sh = 8'h00;
		exp_st = 8'h00;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clock);
		#5 nrst = 1'b1;
		check(parallel_out, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				lfsr = lfsr_next(lfsr);
				step(1'b1, 1'b0, lfsr[0]);
				check({7'h00, serial_cascade_out}, {7'h00, exp_sh[7]});
				check(parallel_out, exp_st);
			end
			step(1'b0, 1'b1, 1'b0);
			check(parallel_out, exp_st);
			step(1'b1, 1'b1, lfsr[3]);
			check(parallel_out, exp_st);
			u_host.clear(i[0], ~i[0]);
			if (i[0]) exp_sh = 8'h00;
			else exp_st = 8'h00;
			check(parallel_out, exp_st);
			check({7'h00, serial_cascade_out}, {7'h00, exp_sh[7]});
		end
		// corner: fill with ones, then edges under both held clears are overridden
		for (int b = 0; b < 8; b++)
			step(1'b1, 1'b0, 1'b1);
		check({7'h00, serial_cascade_out}, 8'h01);
		u_host.set_clear(1'b0, 1'b0);
		u_host.pulse(1'b1, 1'b1, 1'b1);
		u_host.set_clear(1'b1, 1'b1);
		check(parallel_out, 8'h00);
		check({7'h00, serial_cascade_out}, 8'h00);
		stop_test();
	end
endmodule : tb_ssr_top
